// ===== logic/wfo_regs.sv
// Wake filter masks, perfect address table and offload control/status with APB slave
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module wfo_regs #(
    parameter int NUM_WF = 32,
    parameter int NUM_PF = 33,
    parameter logic [15:0] CRC_POLY = 16'h8005,
    parameter logic [15:0] CRC_INIT = 16'hffff
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [wfo_pkg::APB_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Reset-protected filter 0 restore
    input wire logic i_bus_rst,
    input wire logic i_light_rst,
    input wire logic [wfo_pkg::MASK_BITS-1:0] i_filt0_image,
    // Wake pattern CRC check
    input wire wfo_pkg::wfo_rx_byte_t i_rx_byte,
    input wire wfo_pkg::wfo_wf_cfg_t i_wf_cfg,
    output logic o_wf_done,
    output logic o_wf_match,
    // Perfect address check
    input wire wfo_pkg::wfo_addr_chk_t i_addr_chk,
    output logic o_pf_done,
    output logic o_pf_hit,
    // Offload frame events
    input wire wfo_pkg::wfo_rx_evt_t i_rx_evt,
    input wire logic i_resume_done,
    output wfo_pkg::wfo_fate_t o_fate
);
    localparam int MW = NUM_WF * wfo_pkg::MASK_WORDS;
    localparam int MIW = $clog2(MW);
    localparam int PIW = $clog2(NUM_PF * 2);

    // -----------------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------------
    logic [31:0] mask_q [0:MW-1];
    logic [17:0] pf_hi_q [0:NUM_PF-1];
    logic [31:0] pf_lo_q [0:NUM_PF-1];
    logic bypass_q, arp_fwd_q, ns_fwd_q, na_src_q;
    logic ns_seen_q, arp_seen_q, v6_seen_q, v4_seen_q;
    logic ns_ans_q, arp_ans_q, v6_wake_q, v4_wake_q;
    logic res_clr_sts_q, res_clr_en_q;

    // -----------------------------------------------------------------------
    // APB decode
    // -----------------------------------------------------------------------
    logic setup, access, wr;
    logic hit_mask, hit_pf, hit_csr, hit_res;
    logic [11:0] off_mask, off_pf;
    logic [MIW-1:0] mask_idx;
    logic [PIW-1:0] pf_word;
    logic [31:0] rdata_d;
    logic [31:0] csr_rd;

    assign setup = i_psel & ~i_penable;
    assign access = i_psel & i_penable & o_pready;
    assign wr = access & i_pwrite;
    assign off_mask = i_paddr - wfo_pkg::MASK_BASE;
    assign off_pf = i_paddr - wfo_pkg::PF_BASE;
    assign mask_idx = off_mask[MIW+1:2];
    assign pf_word = off_pf[PIW+1:2];

    // Reserved bits assemble as zero
    always_comb begin
        csr_rd = wfo_pkg::RESET_WORD;
        csr_rd[wfo_pkg::CSR_BYPASS] = bypass_q;
        csr_rd[wfo_pkg::CSR_ARP_FWD] = arp_fwd_q;
        csr_rd[wfo_pkg::CSR_NS_FWD] = ns_fwd_q;
        csr_rd[wfo_pkg::CSR_NA_SRC] = na_src_q;
        csr_rd[wfo_pkg::CSR_NS_SEEN] = ns_seen_q;
        csr_rd[wfo_pkg::CSR_ARP_SEEN] = arp_seen_q;
        csr_rd[wfo_pkg::CSR_V6_SEEN] = v6_seen_q;
        csr_rd[wfo_pkg::CSR_V4_SEEN] = v4_seen_q;
        csr_rd[wfo_pkg::CSR_NS_ANS] = ns_ans_q;
        csr_rd[wfo_pkg::CSR_ARP_ANS] = arp_ans_q;
        csr_rd[wfo_pkg::CSR_V6_WAKE] = v6_wake_q;
        csr_rd[wfo_pkg::CSR_V4_WAKE] = v4_wake_q;
    end

    // Address decode and read mux; low two address bits are ignored, except that 3fd-3ff and 505-507 decode as unmapped
    always_comb begin
        hit_mask = 1'b0;
        hit_pf = 1'b0;
        hit_csr = 1'b0;
        hit_res = 1'b0;
        rdata_d = wfo_pkg::RESET_WORD;
        if (i_paddr >= wfo_pkg::MASK_BASE && i_paddr <= wfo_pkg::MASK_LAST) begin
            hit_mask = 1'b1;
            rdata_d = mask_q[mask_idx];
        end else if (i_paddr >= wfo_pkg::PF_BASE && i_paddr <= wfo_pkg::PF_LAST) begin
            hit_pf = 1'b1;
            if (pf_word[0]) begin
                rdata_d = pf_lo_q[pf_word[PIW-1:1]];
            end else begin
                rdata_d = {pf_hi_q[pf_word[PIW-1:1]][17:16], 14'h0000,
                           pf_hi_q[pf_word[PIW-1:1]][15:0]};
            end
        end else if (i_paddr[11:2] == wfo_pkg::CSR_ADDR[11:2]) begin
            hit_csr = 1'b1;
            rdata_d = csr_rd;
        end else if (i_paddr[11:2] == wfo_pkg::RESUME_ADDR[11:2]) begin
            hit_res = 1'b1;
            rdata_d = {30'h0000_0000, res_clr_en_q, res_clr_sts_q};
        end
    end

    // Fixed zero-wait answer: ready in the access cycle, data captured at setup
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_prdata <= wfo_pkg::RESET_WORD;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup & ~(hit_mask | hit_pf | hit_csr | hit_res);
            if (setup) begin
                o_prdata <= i_pwrite ? wfo_pkg::RESET_WORD : rdata_d;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Wake filter byte masks
    // -----------------------------------------------------------------------
    logic restore;
    assign restore = i_bus_rst | i_light_rst;

    // Restore beats a same-cycle write only on the four filter 0 words
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < MW; i++) begin
                mask_q[i] <= wfo_pkg::RESET_WORD;
            end
        end else begin
            for (int i = 0; i < MW; i++) begin
                if (restore && i < wfo_pkg::MASK_WORDS) begin
                    mask_q[i] <= i_filt0_image[i*32 +: 32];
                end else if (wr && hit_mask && mask_idx == MIW'(i)) begin
                    mask_q[i] <= i_pwdata;
                end
            end
        end
    end

    // -----------------------------------------------------------------------
    // Perfect address filter table
    // -----------------------------------------------------------------------
    // No interlock on live rewrites; software drops the valid bit first
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            for (int e = 0; e < NUM_PF; e++) begin
                pf_hi_q[e] <= 18'h00000;
                pf_lo_q[e] <= wfo_pkg::RESET_WORD;
            end
        end else if (wr && hit_pf) begin
            if (pf_word[0]) begin
                pf_lo_q[pf_word[PIW-1:1]] <= i_pwdata;
            end else begin
                pf_hi_q[pf_word[PIW-1:1]] <= {i_pwdata[wfo_pkg::PF_VALID],
                    i_pwdata[wfo_pkg::PF_SRC], i_pwdata[wfo_pkg::PF_HI_MSB:0]};
            end
        end
    end

    // Any valid entry whose selected address field equals the frame's
    logic pf_hit_d, pf_any_d;
    always_comb begin
        pf_hit_d = 1'b0;
        pf_any_d = 1'b0;
        for (int e = 0; e < NUM_PF; e++) begin
            pf_any_d = pf_any_d | pf_hi_q[e][17];
            if (pf_hi_q[e][17]) begin
                if (pf_hi_q[e][16]) begin
                    pf_hit_d = pf_hit_d | (i_addr_chk.sa == {pf_hi_q[e][15:0], pf_lo_q[e]});
                end else begin
                    pf_hit_d = pf_hit_d | (i_addr_chk.da == {pf_hi_q[e][15:0], pf_lo_q[e]});
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_pf_done <= 1'b0;
            o_pf_hit <= 1'b0;
        end else begin
            o_pf_done <= i_addr_chk.valid;
            if (i_addr_chk.valid) begin
                o_pf_hit <= pf_hit_d;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Control and status
    // -----------------------------------------------------------------------
    logic qual, det_arp, det_ns, det_v6, det_v4, csr_wr, res_sts, res_en;
    assign qual = i_rx_evt.fcs_ok &
        (bypass_q | (i_rx_evt.ip_csum_ok & i_rx_evt.l4_csum_ok));
    assign det_arp = i_rx_evt.arp & qual;
    assign det_ns = i_rx_evt.ns & qual;
    assign det_v6 = i_rx_evt.v6_syn & qual;
    assign det_v4 = i_rx_evt.v4_syn & qual;
    assign csr_wr = wr & hit_csr;
    assign res_sts = i_resume_done & res_clr_sts_q;
    assign res_en = i_resume_done & res_clr_en_q;

    // Plain read/write control bits
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            bypass_q <= 1'b0;
            arp_fwd_q <= 1'b0;
            ns_fwd_q <= 1'b0;
            na_src_q <= 1'b0;
            ns_ans_q <= 1'b0;
            arp_ans_q <= 1'b0;
            res_clr_sts_q <= 1'b0;
            res_clr_en_q <= 1'b0;
        end else begin
            if (csr_wr) begin
                bypass_q <= i_pwdata[wfo_pkg::CSR_BYPASS];
                arp_fwd_q <= i_pwdata[wfo_pkg::CSR_ARP_FWD];
                ns_fwd_q <= i_pwdata[wfo_pkg::CSR_NS_FWD];
                na_src_q <= i_pwdata[wfo_pkg::CSR_NA_SRC];
                ns_ans_q <= i_pwdata[wfo_pkg::CSR_NS_ANS];
                arp_ans_q <= i_pwdata[wfo_pkg::CSR_ARP_ANS];
            end
            if (wr && hit_res) begin
                res_clr_sts_q <= i_pwdata[wfo_pkg::RES_CLR_STS];
                res_clr_en_q <= i_pwdata[wfo_pkg::RES_CLR_EN];
            end
        end
    end

    // Wake enables: a software write in the resume cycle wins over the auto-clear
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            v6_wake_q <= 1'b0;
            v4_wake_q <= 1'b0;
        end else if (csr_wr) begin
            v6_wake_q <= i_pwdata[wfo_pkg::CSR_V6_WAKE];
            v4_wake_q <= i_pwdata[wfo_pkg::CSR_V4_WAKE];
        end else if (res_en) begin
            v6_wake_q <= 1'b0;
            v4_wake_q <= 1'b0;
        end
    end

    // Sticky seen flags, write one to clear; a new event beats any clear
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ns_seen_q <= 1'b0;
            arp_seen_q <= 1'b0;
            v6_seen_q <= 1'b0;
            v4_seen_q <= 1'b0;
        end else begin
            ns_seen_q <= det_ns | (ns_seen_q &
                ~(csr_wr & i_pwdata[wfo_pkg::CSR_NS_SEEN]));
            arp_seen_q <= det_arp | (arp_seen_q &
                ~(csr_wr & i_pwdata[wfo_pkg::CSR_ARP_SEEN]));
            v6_seen_q <= det_v6 | (v6_seen_q &
                ~(csr_wr & i_pwdata[wfo_pkg::CSR_V6_SEEN]) & ~res_sts);
            v4_seen_q <= det_v4 | (v4_seen_q &
                ~(csr_wr & i_pwdata[wfo_pkg::CSR_V4_SEEN]) & ~res_sts);
        end
    end

    // Per-frame fate toward the offload responder and receive datapath
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_fate <= '0;
        end else begin
            o_fate.arp_reply <= det_arp & arp_ans_q;
            o_fate.arp_pass <= det_arp & arp_ans_q & arp_fwd_q;
            o_fate.arp_sink <= det_arp & arp_ans_q & ~arp_fwd_q;
            o_fate.ns_reply <= det_ns & ns_ans_q;
            o_fate.ns_pass <= det_ns & ns_ans_q & ns_fwd_q;
            o_fate.ns_sink <= det_ns & ns_ans_q & ~ns_fwd_q;
            o_fate.na_src_dest <= na_src_q;
            o_fate.wake <= (det_v6 & v6_wake_q) | (det_v4 & v4_wake_q);
        end
    end

    // -----------------------------------------------------------------------
    // Wake pattern CRC engine
    // -----------------------------------------------------------------------
    // One filter per frame, chosen at the first byte; cheaper than 32 engines
    wfo_pkg::wfo_wf_state_t st_q;
    wfo_pkg::wfo_wf_cfg_t cfg_q, cfg_use;
    logic [15:0] crc_q, crc_d, pos_q, pos_use, rel;
    logic [31:0] mword;
    logic take, in_win;

    assign cfg_use = i_rx_byte.sof ? i_wf_cfg : cfg_q;
    assign pos_use = i_rx_byte.sof ? 16'h0000 : pos_q;
    assign rel = pos_use - {8'h00, cfg_use.offset};
    assign take = i_rx_byte.valid & (i_rx_byte.sof | (st_q == wfo_pkg::WF_RUN));
    assign in_win = (pos_use >= {8'h00, cfg_use.offset}) && (rel < 16'(wfo_pkg::MASK_BITS));
    assign mword = mask_q[MIW'({cfg_use.sel, rel[6:5]})];

    // Bitwise CRC-16 update over masked bytes, msb first
    always_comb begin
        crc_d = i_rx_byte.sof ? CRC_INIT : crc_q;
        if (in_win && mword[rel[4:0]]) begin
            for (int b = 7; b >= 0; b--) begin
                crc_d = (crc_d[15] ^ i_rx_byte.data[b]) ?
                    ((crc_d << 1) ^ CRC_POLY) : (crc_d << 1);
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st_q <= wfo_pkg::WF_IDLE;
            cfg_q <= '0;
            crc_q <= 16'h0000;
            pos_q <= 16'h0000;
            o_wf_done <= 1'b0;
            o_wf_match <= 1'b0;
        end else begin
            o_wf_done <= 1'b0;
            if (take) begin
                cfg_q <= cfg_use;
                crc_q <= crc_d;
                pos_q <= (pos_use == 16'hffff) ? pos_use : pos_use + 16'h0001;
                case (st_q)
                    wfo_pkg::WF_IDLE: st_q <= i_rx_byte.eof ? wfo_pkg::WF_IDLE : wfo_pkg::WF_RUN;
                    wfo_pkg::WF_RUN: st_q <= i_rx_byte.eof ? wfo_pkg::WF_IDLE : wfo_pkg::WF_RUN;
                    default: st_q <= wfo_pkg::WF_IDLE;
                endcase
                if (i_rx_byte.eof) begin
                    o_wf_done <= 1'b1;
                    o_wf_match <= (crc_d == cfg_use.crc);
                end
            end
        end
    end

    // -----------------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    apb_answer_a: assert property (setup |=> o_pready ##1 !o_pready)
        else $error("APB answer not in the access cycle");
    strict_csum_a: assert property (
        (i_rx_evt.v4_syn && !bypass_q && !i_rx_evt.ip_csum_ok && !v4_seen_q) |=> !v4_seen_q)
        else $error("Bad checksum frame set the v4 seen flag");
    bypass_csum_a: assert property (
        (i_rx_evt.arp && i_rx_evt.fcs_ok && bypass_q) |=> arp_seen_q)
        else $error("Bypassed checksum frame not detected");
    arp_fate_a: assert property (
        o_fate.arp_pass |-> $past(arp_fwd_q) && !o_fate.arp_sink)
        else $error("ARP pass without forward select");
    ns_sticky_a: assert property (
        det_ns |=> ns_seen_q [*2] or (ns_seen_q ##1 $past(csr_wr)))
        else $error("NS seen flag lost");
    resume_status_a: assert property (
        (res_sts && !det_v6 && !det_v4) |=> !v6_seen_q && !v4_seen_q)
        else $error("Resume did not clear SYN seen flags");
    resume_enable_a: assert property (
        (res_en && !csr_wr) |=> !v6_wake_q && !v4_wake_q)
        else $error("Resume did not clear SYN wake enables");
    invalid_entry_a: assert property (
        (i_addr_chk.valid && !pf_any_d) |=> o_pf_done && !o_pf_hit)
        else $error("Address hit without a valid entry");
    restore_mask_a: assert property (
        restore |=> mask_q[0] == $past(i_filt0_image[31:0]) && mask_q[3] ==
        $past(i_filt0_image[127:96]))
        else $error("Filter 0 mask not restored");
    reserved_zero_a: assert property (
        (setup && hit_csr && !i_pwrite) |=> o_prdata[30:11] == 20'h00000)
        else $error("Reserved status bits read nonzero");

    wake_cov_c: cover property (det_v6 && v6_wake_q ##1 o_fate.wake);
    pf_hit_c: cover property (o_pf_done && o_pf_hit);
    wf_match_c: cover property (o_wf_done && o_wf_match);
    set_clear_c: cover property (det_arp && csr_wr && i_pwdata[wfo_pkg::CSR_ARP_SEEN]);
endmodule : wfo_regs

// ===== logic/wfo_pkg.sv
// Package: address map, field positions and carriers of the wake/offload register block
// ---------------------------------------------------------------------------
// Operation
// - Thirty-two wake filters, each with a 128-bit byte mask in four words.
// - A set mask bit j feeds frame byte offset+j to the CRC; clear skips it.
// - Mask word 0 holds bits 31:0, word 3 holds bits 127:96.
// - A perfect filter entry matches only while its valid bit 31 is set.
// - Entry bit 30 picks source address when set, destination when clear.
// - Entry word 0 bits 15:0 hold address 47:32; word 1 holds 31:0.
// - Checksum bypass clear: IP, TCP checksums and FCS must all pass.
// - Checksum bypass set: only the FCS is checked for offload frames.
// - Bit 10 chooses passing or sinking of ARP frames handled by offload.
// - Bit 9 chooses passing or sinking of NS frames handled by offload.
// - Bit 8 picks advert source: programmed address or solicited target.
// - Bit 7 is set on a valid NS frame, cleared by software write.
// - Bit 6 is set on a valid ARP frame, cleared by software write.
// - Bits 5 and 4 set on valid v6 and v4 SYN frames, write clears.
// - SYN seen flags clear on resume completion when status clearing is on.
// - Bit 3 enables NS answering, bit 2 enables ARP answering.
// - Bit 1 enables wake on v6 SYN, bit 0 wake on v4 SYN.
// - Both SYN wake enables clear on resume when enable clearing is on.
// - Filter CRC over masked bytes compared with expected 16-bit CRC.
// - Bus or light reset restores filter 0 mask from the loaded image.
// ---------------------------------------------------------------------------
package wfo_pkg;
    // -----------------------------------------------------------------------
    // Address map
    // -----------------------------------------------------------------------
    localparam int APB_AW = 12;
    localparam logic [11:0] MASK_BASE = 12'h200;
    localparam logic [11:0] MASK_LAST = 12'h3fc;
    localparam logic [11:0] PF_BASE = 12'h400;
    localparam logic [11:0] PF_LAST = 12'h504;
    localparam logic [11:0] CSR_ADDR = 12'h600;
    localparam logic [11:0] RESUME_ADDR = 12'h604;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam int MASK_WORDS = 4;
    localparam int MASK_BITS = 128;
    // -----------------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------------
    localparam int CSR_BYPASS = 31;
    localparam int CSR_ARP_FWD = 10;
    localparam int CSR_NS_FWD = 9;
    localparam int CSR_NA_SRC = 8;
    localparam int CSR_NS_SEEN = 7;
    localparam int CSR_ARP_SEEN = 6;
    localparam int CSR_V6_SEEN = 5;
    localparam int CSR_V4_SEEN = 4;
    localparam int CSR_NS_ANS = 3;
    localparam int CSR_ARP_ANS = 2;
    localparam int CSR_V6_WAKE = 1;
    localparam int CSR_V4_WAKE = 0;
    localparam int RES_CLR_STS = 0;
    localparam int RES_CLR_EN = 1;
    localparam int PF_VALID = 31;
    localparam int PF_SRC = 30;
    localparam int PF_HI_MSB = 15;
    // -----------------------------------------------------------------------
    // Carriers
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [7:0] data;
    } wfo_rx_byte_t;
    typedef struct packed {
        logic [4:0] sel;
        logic [7:0] offset;
        logic [15:0] crc;
    } wfo_wf_cfg_t;
    typedef struct packed {
        logic arp;
        logic ns;
        logic v6_syn;
        logic v4_syn;
        logic fcs_ok;
        logic ip_csum_ok;
        logic l4_csum_ok;
    } wfo_rx_evt_t;
    typedef struct packed {
        logic valid;
        logic [47:0] da;
        logic [47:0] sa;
    } wfo_addr_chk_t;
    typedef struct packed {
        logic arp_reply;
        logic arp_pass;
        logic arp_sink;
        logic ns_reply;
        logic ns_pass;
        logic ns_sink;
        logic na_src_dest;
        logic wake;
    } wfo_fate_t;
    typedef enum logic {WF_IDLE, WF_RUN} wfo_wf_state_t;
endpackage : wfo_pkg

// ===== tb/wfo_net_model.sv
// Network side model: turns a bench command into a one-cycle receive event
`timescale 1ns/1ps
module wfo_net_model (
    // Clock and command
    input wire logic i_clk_sys,
    input wire logic i_go,
    input wire logic [3:0] i_kind,
    input wire logic [2:0] i_ok,
    // Event toward the block
    output wfo_pkg::wfo_rx_evt_t o_evt
);
    // Check results fail only where the bench commands it; idle cycles carry no event
    always @(posedge i_clk_sys) begin
        o_evt <= i_go ? {i_kind, i_ok} : '0;
    end
endmodule : wfo_net_model

// ===== tb/test_wfo_regs.sv
// Self-checking bench for the wake/offload register block
`timescale 1ns/1ps
module test_wfo_regs;
    logic i_clk_sys, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0, res = 1'b0;
    logic brst = 1'b0, light_device_reset = 1'b0, pready, pslverr, pf_done, pf_hit, er;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, w, r, csr_m = '0;
    logic [3:0] kind = '0;
    logic [2:0] ok = '0;
    logic [127:0] img = '0;
    wfo_pkg::wfo_rx_evt_t evt;
    wfo_pkg::wfo_addr_chk_t ac = '0;
    wfo_pkg::wfo_fate_t fate;
    wfo_pkg::wfo_rx_byte_t rxb = '0;
    wfo_pkg::wfo_wf_cfg_t wcfg = '0;
    logic wf_done, wf_match;
    int seed = 32'h0928, miscompares = 0, n_compared = 0;
    // Frame bytes and filter choice from the bench; filter 0 mask is the restore image
    wfo_regs dut_u (.i_clk_sys(i_clk_sys), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_bus_rst(brst), .i_light_rst(light_device_reset),
        .i_filt0_image(img), .i_rx_byte(rxb), .i_wf_cfg(wcfg), .o_wf_done(wf_done),
        .o_wf_match(wf_match),
        .i_addr_chk(ac), .o_pf_done(pf_done), .o_pf_hit(pf_hit), .i_rx_evt(evt),
        .i_resume_done(res), .o_fate(fate));
    wfo_net_model net_u (.i_clk_sys(i_clk_sys), .i_go(go), .i_kind(kind), .i_ok(ok),
        .o_evt(evt));
    // 100 MHz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic finish_test;
        $display("compared %0d, wrong %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held until pready seen high; data taken at that edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk_sys);
        psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= a; pwdata <= d;
        @(posedge i_clk_sys);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // Expected fate: bypass keeps only the frame check sequence test
    function automatic logic [7:0] fate_x(logic [31:0] c, logic [3:0] k, logic [2:0] o);
        logic q, a, s;
        q = o[2] & (c[31] | (o[1] & o[0]));
        a = q & k[3] & c[2];
        s = q & k[2] & c[3];
        return {a, a & c[10], a & ~c[10], s, s & c[9], s & ~c[9], c[8],
            q & ((k[1] & c[1]) | (k[0] & c[0]))};
    endfunction : fate_x
    task automatic ev(input logic [3:0] k, input logic [2:0] o);
        @(posedge i_clk_sys); go <= 1'b1; kind <= k; ok <= o;
        @(posedge i_clk_sys); go <= 1'b0;
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk({24'h0, fate}, {24'h0, fate_x(csr_m, k, o)});
        if (o[2] & (csr_m[31] | (o[1] & o[0]))) csr_m[7:4] = csr_m[7:4] | {k[2], k[3], k[1:0]};
    endtask : ev
    task automatic pfc(input logic [47:0] da, input logic [47:0] sa, input logic hit);
        @(posedge i_clk_sys); ac <= {1'b1, da, sa};
        @(posedge i_clk_sys); ac.valid <= 1'b0;
        @(negedge i_clk_sys);
        chk({30'h0, pf_done, pf_hit}, {30'h0, 1'b1, hit});
    endtask : pfc
    // Frame through filter 0; CRC of masked bytes, low bit flipped when bad
    task automatic wf(input int n, input logic [7:0] off, input logic bad);
        logic [15:0] c;
        logic [7:0] q[$];
        c = 16'hffff;
        repeat (n) q.push_back(8'($random(seed)));
        for (int p = 0; p < n; p++) begin
            if (p >= off && p - off < wfo_pkg::MASK_BITS && img[p - off]) begin
                for (int b = 7; b >= 0; b--) begin
                    c = (c[15] ^ q[p][b]) ? ((c << 1) ^ 16'h8005) : (c << 1);
                end
            end
        end
        for (int p = 0; p < n; p++) begin
            @(posedge i_clk_sys);
            rxb <= {1'b1, p == 0, p == n - 1, q[p]};
            wcfg <= {5'h00, off, c ^ {15'h0000, bad}};
        end
        @(posedge i_clk_sys);
        rxb <= '0;
        @(negedge i_clk_sys);
        chk({30'h0, wf_done, wf_match}, {30'h0, 1'b1, ~bad});
    endtask : wf
    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_clk_sys);
        rst <= 1'b0;
        apb(0, 12'h600, 0); chk(rd, 0);
        apb(0, 12'h3fc, 0); chk(rd, 0);
        apb(0, 12'h700, 0); chk({rd[30:0], er}, 1);
        w = $random(seed);
        apb(1, 12'h3fc, w); apb(0, 12'h3fc, 0); chk(rd, w);
        // Random control values with events of every kind
        repeat (48) begin
            w = $random(seed);
            r = $random(seed);
            apb(1, 12'h600, w);
            csr_m = (w & 32'h8000_070f) | (csr_m & ~w & 32'h0000_00f0);
            ev(4'h1 << r[1:0], r[4:2]);
            apb(0, 12'h600, 0); chk(rd, csr_m);
        end
        // Resume completion clears SYN flags and SYN wake enables
        apb(1, 12'h604, 3); apb(1, 12'h600, 32'h0000_00f3);
        csr_m = 32'h0000_0003;
        ev(4'h2, 3'h7); ev(4'h1, 3'h7);
        @(posedge i_clk_sys); res <= 1'b1;
        @(posedge i_clk_sys); res <= 1'b0;
        apb(0, 12'h600, 0); chk(rd, 0);
        // Filter 0 restore from image on both device resets
        img <= {$random(seed), $random(seed), $random(seed), $random(seed)};
        @(posedge i_clk_sys); brst <= 1'b1;
        @(posedge i_clk_sys); brst <= 1'b0;
        apb(0, 12'h200, 0); chk(rd, img[31:0]);
        apb(0, 12'h20c, 0); chk(rd, img[127:96]);
        img <= ~img;
        @(posedge i_clk_sys); light_device_reset <= 1'b1;
        @(posedge i_clk_sys); light_device_reset <= 1'b0;
        apb(0, 12'h204, 0); chk(rd, img[63:32]);
        // Wake pattern CRC: frame past the window, wrong CRC, single byte frame
        wf(140, 8'h05, 1'b0);
        wf(9, 8'h02, 1'b1);
        wf(1, 8'h00, 1'b0);
        // Perfect filter entry 1: reserved bits dropped, valid then source select
        apb(1, 12'h40c, 32'h5678_9abc); apb(1, 12'h408, 32'h3fff_1234);
        apb(0, 12'h408, 0); chk(rd, 32'h0000_1234);
        pfc(48'h1234_5678_9abc, 0, 1'b0);
        apb(1, 12'h408, 32'h8000_1234);
        pfc(48'h1234_5678_9abc, 0, 1'b1);
        apb(1, 12'h408, 32'h0000_1234); apb(1, 12'h408, 32'hc000_1234);
        pfc(48'h1234_5678_9abc, 0, 1'b0);
        pfc(0, 48'h1234_5678_9abc, 1'b1);
        finish_test();
    end
endmodule : test_wfo_regs
